/* hbtu_pkg.sv */
// package for the hart breakpoint trigger unit: csr numbers, field layout, codes
// assumes a 32-bit hart whose csr file forwards trigger csr accesses here
package hbtu_pkg;

    // ************************************************************
    // csr addresses and sizes
    // ************************************************************
    localparam logic [11:0] CSR_SELECT = 12'h07a0;
    localparam logic [11:0] CSR_DATA1 = 12'h07a1;
    localparam logic [11:0] CSR_DATA2 = 12'h07a2;
    localparam logic [11:0] CSR_DATA3 = 12'h07a3;
    localparam int NUM_TRIG = 2;
    localparam int XLEN = 32;

    // ************************************************************
    // control word field positions
    // ************************************************************
    localparam int F_LOAD = 0;
    localparam int F_STORE = 1;
    localparam int F_EXEC = 2;
    localparam int F_USER = 3;
    localparam int F_SUPER = 4;
    localparam int F_MACH = 6;
    localparam int F_MATCH_LO = 7;
    localparam int F_CHAIN = 11;
    localparam int F_ACTION_LO = 12;
    localparam int F_MASKMAX_LO = 21;
    localparam int F_DMODE = 27;
    localparam int F_TYPE_LO = 28;

    // ************************************************************
    // constant field values
    // ************************************************************
    localparam logic [3:0] TYPE_ADDR_MATCH = 4'h2;
    localparam logic [3:0] TYPE_NONE = 4'h0;
    localparam logic [5:0] MASKMAX_VAL = 6'h04;
    localparam logic [3:0] ACT_BREAK = 4'h0;
    localparam logic [3:0] ACT_DEBUG = 4'h1;
    localparam logic [3:0] MATCH_EXACT = 4'h0;
    localparam logic [3:0] MATCH_NAPOT = 4'h1;
    localparam logic [3:0] MATCH_GE = 4'h2;
    localparam logic [3:0] MATCH_LT = 4'h3;
    localparam logic [1:0] PRIV_U = 2'h0;
    localparam logic [1:0] PRIV_S = 2'h1;
    localparam logic [1:0] PRIV_M = 2'h3;
    localparam logic [31:0] CAUSE_BREAKPOINT = 32'h0000_0003;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ************************************************************
    // carriers
    // ************************************************************
    // one access presented by the pipeline for checking
    typedef struct packed {
        logic valid;
        logic is_load;
        logic is_store;
        logic is_fetch;
        logic [1:0] priv;
        logic [31:0] addr;
        logic [2:0] size_log2;
    } hbtu_access_t;

    // stored per-trigger control state
    typedef struct packed {
        logic dmode;
        logic [3:0] action;
        logic chain;
        logic [3:0] match;
        logic m;
        logic s;
        logic u;
        logic x;
        logic w;
        logic r;
    } hbtu_ctrl_t;

    // trap handed to the pipeline
    typedef struct packed {
        logic valid;
        logic to_debug;
        logic [31:0] cause;
        logic [31:0] badaddr;
    } hbtu_trap_t;

endpackage : hbtu_pkg

/* hbtu_trigger_unit.sv */
// hart breakpoint trigger unit: two address triggers behind csr select/data words
// holds select, control and address storage, comparators, chaining and trap staging
// assumes csr accesses and pipeline accesses come from logic on clk_i
// assumes the hart squashes the access one cycle later when trap_o.valid rises
// assumes the hart drives csr_debug_mode_i as a clean level from its own state
`timescale 1ns/100ps

module hbtu_trigger_unit
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // csr port from the hart
    input wire logic csr_req_i,
    input wire logic csr_we_i,
    input wire logic [11:0] csr_addr_i,
    input wire logic [31:0] csr_wdata_i,
    input wire logic csr_debug_mode_i,
    output logic [31:0] csr_rdata_o,
    output logic csr_ack_o,
    output logic csr_illegal_o,
    // access check from the pipeline
    input wire hbtu_pkg::hbtu_access_t acc_i,
    output hbtu_pkg::hbtu_trap_t trap_o
);

    // ************************************************************
    // reset release
    // ************************************************************
    // first stage, read only by the second
    logic rst_s1_q;
    // released reset used by every other flop
    logic rst_n_q;

    // async assert, two-flop synchronous release
    // release is retimed so all flops below leave reset on one edge;
    // the hart must hold off its first request until two edges have passed
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ************************************************************
    // trigger storage
    // ************************************************************
    // per-trigger control fields; constant fields are rebuilt on read
    hbtu_pkg::hbtu_ctrl_t ctrl_q [hbtu_pkg::NUM_TRIG];
    // per-trigger address word, low ones double as the napot mask
    logic [31:0] addr_q [hbtu_pkg::NUM_TRIG];
    // trigger reached through the data words;
    // two triggers only, so the index needs a single bit
    logic sel_q;
    // readback image of each control word
    logic [31:0] ctrl_rd [hbtu_pkg::NUM_TRIG];
    // raw condition match of each trigger, before chaining
    logic hit [hbtu_pkg::NUM_TRIG];

    // ************************************************************
    // csr decode
    // ************************************************************
    // one strobe per implemented csr number
    logic acc_sel;
    logic acc_d1;
    logic acc_d2;
    logic acc_d3;
    logic acc_known;
    // refused data-word access from machine mode
    logic blocked;
    assign acc_sel = csr_req_i && (csr_addr_i == hbtu_pkg::CSR_SELECT);
    assign acc_d1 = csr_req_i && (csr_addr_i == hbtu_pkg::CSR_DATA1);
    assign acc_d2 = csr_req_i && (csr_addr_i == hbtu_pkg::CSR_DATA2);
    assign acc_d3 = csr_req_i && (csr_addr_i == hbtu_pkg::CSR_DATA3);
    // known number: the only requests that are answered at all
    assign acc_known = acc_sel || acc_d1 || acc_d2 || acc_d3;
    // machine mode may not touch a debug-only trigger's data words;
    // the write is dropped and the read returns zero so nothing leaks
    assign blocked = (acc_d1 || acc_d2 || acc_d3) && !csr_debug_mode_i && ctrl_q[sel_q].dmode;

    // select index: only implemented triggers are held, so bit 0 only
    // upper index bits are dropped, so the value always names a real trigger
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            sel_q <= 1'b0;
        else if (acc_sel && csr_we_i)
            sel_q <= csr_wdata_i[0];
    end

    // ************************************************************
    // per-trigger registers and comparators
    // ************************************************************
    // one register set and one comparator per trigger
    genvar gi;
    generate
        for (gi = 0; gi < hbtu_pkg::NUM_TRIG; gi++)
        begin : g_trig
            // write strobes for this trigger's two data words
            logic wr_ctrl;
            logic wr_addr;
            // legalised match and action codes of the incoming write
            logic [3:0] wmatch;
            logic [3:0] wact;
            // napot compare mask and its complement
            logic [31:0] care;
            logic [31:0] lo_mask;
            // last byte address of the access
            logic [31:0] acc_last;
            // partial match conditions
            logic addr_hit;
            logic kind_ok;
            logic priv_ok;

            // a refused machine access must leave the trigger untouched
            assign wr_ctrl = acc_d1 && csr_we_i && !blocked && (sel_q == 1'(gi));
            assign wr_addr = acc_d2 && csr_we_i && !blocked && (sel_q == 1'(gi));
            // unsupported match codes fall back to exact, the narrowest match
            assign wmatch = (csr_wdata_i[hbtu_pkg::F_MATCH_LO +: 4] > hbtu_pkg::MATCH_LT)
                ? hbtu_pkg::MATCH_EXACT : csr_wdata_i[hbtu_pkg::F_MATCH_LO +: 4];
            // only break or debug kept; any other code reads back as break
            assign wact = (csr_wdata_i[hbtu_pkg::F_ACTION_LO +: 4] == hbtu_pkg::ACT_DEBUG)
                ? hbtu_pkg::ACT_DEBUG : hbtu_pkg::ACT_BREAK;

            // control word; dmode only writable from debug mode
            // fields are stored even when their combination can never match
            always_ff @(posedge clk_i or negedge rst_n_q)
            begin
                if (!rst_n_q)
                    ctrl_q[gi] <= '0;
                else if (wr_ctrl)
                begin
                    ctrl_q[gi].r <= csr_wdata_i[hbtu_pkg::F_LOAD];
                    ctrl_q[gi].w <= csr_wdata_i[hbtu_pkg::F_STORE];
                    ctrl_q[gi].x <= csr_wdata_i[hbtu_pkg::F_EXEC];
                    ctrl_q[gi].u <= csr_wdata_i[hbtu_pkg::F_USER];
                    ctrl_q[gi].s <= csr_wdata_i[hbtu_pkg::F_SUPER];
                    ctrl_q[gi].m <= csr_wdata_i[hbtu_pkg::F_MACH];
                    ctrl_q[gi].match <= wmatch;
                    ctrl_q[gi].chain <= csr_wdata_i[hbtu_pkg::F_CHAIN];
                    ctrl_q[gi].action <= wact;
                    // machine code can neither claim nor release a debug-owned trigger
                    ctrl_q[gi].dmode <= csr_debug_mode_i ? csr_wdata_i[hbtu_pkg::F_DMODE] : ctrl_q[gi].dmode;
                end
            end

            // full-width address/mask word
            // every bit stores; no alignment is forced on the address
            always_ff @(posedge clk_i or negedge rst_n_q)
            begin
                if (!rst_n_q)
                    addr_q[gi] <= hbtu_pkg::ZERO_WORD;
                else if (wr_addr)
                    addr_q[gi] <= csr_wdata_i;
            end

            // readback image; size, timing, select and reserved read zero
            // bits 5 and 20 are reserved and stay zero;
            // type and maskmax are constants and take no storage
            always_comb
            begin
                ctrl_rd[gi] = hbtu_pkg::ZERO_WORD;
                ctrl_rd[gi][hbtu_pkg::F_LOAD] = ctrl_q[gi].r;
                ctrl_rd[gi][hbtu_pkg::F_STORE] = ctrl_q[gi].w;
                ctrl_rd[gi][hbtu_pkg::F_EXEC] = ctrl_q[gi].x;
                ctrl_rd[gi][hbtu_pkg::F_USER] = ctrl_q[gi].u;
                ctrl_rd[gi][hbtu_pkg::F_SUPER] = ctrl_q[gi].s;
                ctrl_rd[gi][hbtu_pkg::F_MACH] = ctrl_q[gi].m;
                ctrl_rd[gi][hbtu_pkg::F_MATCH_LO +: 4] = ctrl_q[gi].match;
                ctrl_rd[gi][hbtu_pkg::F_CHAIN] = ctrl_q[gi].chain;
                ctrl_rd[gi][hbtu_pkg::F_ACTION_LO +: 4] = ctrl_q[gi].action;
                ctrl_rd[gi][hbtu_pkg::F_MASKMAX_LO +: 6] = hbtu_pkg::MASKMAX_VAL;
                ctrl_rd[gi][hbtu_pkg::F_DMODE] = ctrl_q[gi].dmode;
                ctrl_rd[gi][hbtu_pkg::F_TYPE_LO +: 4] = hbtu_pkg::TYPE_ADDR_MATCH;
            end

            // trailing ones plus the zero above them are don't-care bits
            // the increment carries through the trailing ones, so the xor marks those bits and the zero above them
            // any mask length is honoured although maskmax reports a smaller limit
            assign lo_mask = addr_q[gi] ^ (addr_q[gi] + 32'h0000_0001);
            assign care = ~lo_mask;
            // last byte of a wide access, for any-byte overlap
            // wraps at the top of the address space; a wide access there may be missed
            assign acc_last = acc_i.addr + ((32'h0000_0001 << acc_i.size_log2) - 32'h0000_0001);

            // address comparison per match type; each arm tests the bytes
            // from acc_i.addr to acc_last against the trigger's range
            always_comb
            begin
                case (ctrl_q[gi].match)
                    hbtu_pkg::MATCH_EXACT:
                        // the one watched byte lies inside the access
                        addr_hit = (acc_i.addr <= addr_q[gi]) && (acc_last >= addr_q[gi]);
                    hbtu_pkg::MATCH_NAPOT:
                        // range overlap; masked low bits excluded
                        // both ends are masked, so a straddling access still hits
                        addr_hit = ((acc_i.addr & care) <= (addr_q[gi] & care))
                            && ((acc_last & care) >= (addr_q[gi] & care));
                    hbtu_pkg::MATCH_GE:
                        // any byte at or above the lower bound
                        addr_hit = acc_last >= addr_q[gi];
                    hbtu_pkg::MATCH_LT:
                        // any byte below the bound one past the range
                        addr_hit = acc_i.addr < addr_q[gi];
                    default:
                        // unreachable, writes are legalised
                        addr_hit = 1'b0;
                endcase
            end

            // access kind gate; an all-zero enable set never matches
            assign kind_ok = (ctrl_q[gi].r && acc_i.is_load) || (ctrl_q[gi].w && acc_i.is_store)
                || (ctrl_q[gi].x && acc_i.is_fetch);
            // privilege gate; the reserved privilege code matches nothing
            assign priv_ok = (ctrl_q[gi].m && (acc_i.priv == hbtu_pkg::PRIV_M))
                || (ctrl_q[gi].s && (acc_i.priv == hbtu_pkg::PRIV_S))
                || (ctrl_q[gi].u && (acc_i.priv == hbtu_pkg::PRIV_U));
            // no triggers fire while the hart sits in debug mode,
            // so the debug program cannot retrigger on its own accesses
            assign hit[gi] = acc_i.valid && !csr_debug_mode_i && kind_ok && priv_ok && addr_hit;
        end
    endgenerate

    // ************************************************************
    // chaining and trap generation
    // ************************************************************
    // per-access firing decisions after chaining
    logic fire0;
    logic fire1;
    logic fire_any;
    logic dbg0;
    logic dbg1;
    logic fire_dbg;
    // next values of the trap payload
    logic [31:0] cause_d;
    logic [31:0] badaddr_d;
    // chained lower trigger acts only through the higher one;
    // an unchained pair acts independently, either one may fire
    assign fire0 = hit[0] && !ctrl_q[0].chain;
    assign fire1 = hit[1] && (!ctrl_q[0].chain || hit[0]);
    assign fire_any = fire0 || fire1;
    // debug action only honoured for a debug-owned trigger; a machine-owned
    // trigger asking for debug falls back to a breakpoint and cannot seize the hart
    assign dbg0 = fire0 && (ctrl_q[0].action == hbtu_pkg::ACT_DEBUG) && ctrl_q[0].dmode;
    assign dbg1 = fire1 && (ctrl_q[1].action == hbtu_pkg::ACT_DEBUG) && ctrl_q[1].dmode;
    // debug entry wins when both triggers fire on one access
    assign fire_dbg = dbg0 || dbg1;

    // ************************************************************
    // trap staging
    // ************************************************************
    // debug entry reports no cause, leaving machine state alone
    assign cause_d = (fire_any && !fire_dbg) ? hbtu_pkg::CAUSE_BREAKPOINT : hbtu_pkg::ZERO_WORD;
    assign badaddr_d = (fire_any && !fire_dbg) ? acc_i.addr : hbtu_pkg::ZERO_WORD;

    // trap registered one cycle after the access so the pipeline kills it precisely;
    // valid and payload move together so the hart never sees a half-formed trap
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            trap_o <= '0;
        else
        begin
            trap_o.valid <= fire_any;
            trap_o.to_debug <= fire_dbg;
            trap_o.cause <= cause_d;
            trap_o.badaddr <= badaddr_d;
        end
    end

    // ************************************************************
    // csr read and answer
    // ************************************************************
    // read mux: select index, control image or address word;
    // data3 is not implemented and, like a refused read, returns zero
    logic [31:0] rd_d;
    always_comb
    begin
        rd_d = hbtu_pkg::ZERO_WORD;
        if (acc_sel)
            rd_d = {31'h0000_0000, sel_q};
        else if (acc_d1)
        begin
            rd_d = ctrl_rd[sel_q];
            // debug-claimed trigger looks absent to machine mode
            // a refused read is zeroed below anyway; this keeps the type nibble right on its own
            if (ctrl_q[sel_q].dmode && !csr_debug_mode_i)
                rd_d[hbtu_pkg::F_TYPE_LO +: 4] = hbtu_pkg::TYPE_NONE;
        end
        else if (acc_d2)
            rd_d = addr_q[sel_q];
        if (blocked)
            rd_d = hbtu_pkg::ZERO_WORD;
    end

    // one-cycle answer; unknown csr numbers are not answered
    // illegal rides with ack so the hart raises the exception in the same cycle;
    // rdata is zero on cycles without a request, so stale words never linger
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            csr_rdata_o <= hbtu_pkg::ZERO_WORD;
            csr_ack_o <= 1'b0;
            csr_illegal_o <= 1'b0;
        end
        else
        begin
            csr_rdata_o <= rd_d;
            csr_ack_o <= acc_known;
            csr_illegal_o <= blocked;
        end
    end

endmodule : hbtu_trigger_unit

/* hbtu_pipe_model.sv */
// pipeline model: presents one access per request and releases the bus between accesses
// assumes the bench raises req_i.valid for one cycle just after a rising edge
`timescale 1ns/100ps

module hbtu_pipe_model
(
    // clock
    input wire logic clk_i,
    // access wanted by the bench
    input wire hbtu_pkg::hbtu_access_t req_i,
    // access seen by the trigger unit
    output hbtu_pkg::hbtu_access_t acc_o
);
    // ********
    // access stage
    // ********
    initial acc_o = '0;

    // released address inverts each cycle so a stale match cannot hide
    always @(posedge clk_i)
    begin
        if (req_i.valid)
            acc_o <= req_i;
        else
        begin
            acc_o.valid <= 1'b0;
            acc_o.addr <= ~acc_o.addr;
        end
    end
endmodule : hbtu_pipe_model

/* hbtu_trigger_monitor.sv */
// checker for the trigger unit ports: csr answers and trap contents
// assumes it is bound into hbtu_trigger_unit and sees only its ports
`timescale 1ns/100ps

module hbtu_trigger_monitor
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // csr port
    input wire logic csr_req_i,
    input wire logic csr_we_i,
    input wire logic [11:0] csr_addr_i,
    input wire logic [31:0] csr_wdata_i,
    input wire logic csr_debug_mode_i,
    input wire logic [31:0] csr_rdata_o,
    input wire logic csr_ack_o,
    input wire logic csr_illegal_o,
    // access port
    input wire hbtu_pkg::hbtu_access_t acc_i,
    input wire hbtu_pkg::hbtu_trap_t trap_o
);
    // ********
    // csr answers
    // ********
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // a legal control word access, read or write, not refused
    sequence ctl_rd;
        csr_ack_o && !csr_illegal_o && $past(csr_addr_i) == hbtu_pkg::CSR_DATA1;
    endsequence

    chk_ack_timing: assert property (csr_req_i && csr_addr_i[11:2] == 10'h1e8 |=> csr_ack_o)
        else $error("csr request without ack");
    chk_ack_cause: assert property (csr_ack_o |-> $past(csr_req_i))
        else $error("ack without request");
    chk_type_two: assert property (ctl_rd |-> csr_rdata_o[31:28] == hbtu_pkg::TYPE_ADDR_MATCH)
        else $error("type field wrong");
    chk_maskmax_four: assert property (ctl_rd |-> csr_rdata_o[26:21] == hbtu_pkg::MASKMAX_VAL)
        else $error("maskmax field wrong");
    chk_fixed_zeros: assert property (ctl_rd |-> csr_rdata_o[20:16] == 5'h00 && !csr_rdata_o[5])
        else $error("hard-wired field not zero");
    chk_illegal_view: assert property (csr_illegal_o |-> csr_ack_o && csr_rdata_o == 32'h0000_0000 && !$past(csr_debug_mode_i))
        else $error("illegal answer malformed");

    // ********
    // trap contents
    // ********
    chk_trap_source: assert property (trap_o.valid |-> $past(acc_i.valid) && !$past(csr_debug_mode_i))
        else $error("trap without access");
    chk_break_cause: assert property (trap_o.valid && !trap_o.to_debug |-> trap_o.cause == hbtu_pkg::CAUSE_BREAKPOINT && trap_o.badaddr == $past(acc_i.addr))
        else $error("breakpoint cause or address wrong");
    chk_debug_quiet: assert property (trap_o.valid && trap_o.to_debug |-> trap_o.cause == 32'h0000_0000 && trap_o.badaddr == 32'h0000_0000)
        else $error("debug entry altered machine state");

    // main scenarios reached
    cover property (trap_o.valid && trap_o.to_debug);
    cover property (trap_o.valid && !trap_o.to_debug);
    cover property (csr_illegal_o);
endmodule : hbtu_trigger_monitor

bind hbtu_trigger_unit hbtu_trigger_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .csr_req_i(csr_req_i),
    .csr_we_i(csr_we_i), .csr_addr_i(csr_addr_i), .csr_wdata_i(csr_wdata_i), .csr_debug_mode_i(csr_debug_mode_i),
    .csr_rdata_o(csr_rdata_o), .csr_ack_o(csr_ack_o), .csr_illegal_o(csr_illegal_o), .acc_i(acc_i), .trap_o(trap_o));

/* test_hart_breakpoint_trigger_unit.sv */
// testbench for the trigger unit: table of match cases, then csr and chaining edge cases
// assumes hbtu_pipe_model.sv and the bound checker are compiled alongside
`timescale 1ns/100ps

module test_hart_breakpoint_trigger_unit;
    // ********
    // signals and case table
    // ********
    typedef struct packed {logic [31:0] c; logic [31:0] m; logic [2:0] k; logic [1:0] p;
        logic [31:0] ad; logic [2:0] s; logic [1:0] ev;} hbtu_row_t;
    logic clk_i, rst_n_i, req, we, dbg, aq, iq;
    logic [11:0] a;
    logic [31:0] wd, rq, tv, tc, tb;
    wire logic [31:0] rd;
    wire logic ack, ill;
    hbtu_pkg::hbtu_access_t pr, acc;
    hbtu_pkg::hbtu_trap_t trap;
    int errors, total_checks;
    // control, address, kind, priv, access address, size, {trap, debug}
    hbtu_row_t rows [12] = '{
        '{32'h0000_0041, 32'h0000_1000, 3'h1, 2'h3, 32'h0000_1000, 3'h0, 2'h2},
        '{32'h0000_0041, 32'h0000_1000, 3'h2, 2'h3, 32'h0000_1000, 3'h0, 2'h0},
        '{32'h0000_0046, 32'h0000_1000, 3'h4, 2'h3, 32'h0000_1000, 3'h0, 2'h2},
        '{32'h0000_000f, 32'h0000_1000, 3'h1, 2'h3, 32'h0000_1000, 3'h0, 2'h0},
        '{32'h0000_0012, 32'h0000_1000, 3'h2, 2'h1, 32'h0000_1000, 3'h0, 2'h2},
        '{32'h0000_0009, 32'h0000_1000, 3'h1, 2'h0, 32'h0000_1000, 3'h0, 2'h2},
        '{32'h0000_0041, 32'h0000_1003, 3'h1, 2'h3, 32'h0000_1000, 3'h2, 2'h2},
        '{32'h0000_00c1, 32'h0000_1001, 3'h1, 2'h3, 32'h0000_1003, 3'h0, 2'h2},
        '{32'h0000_00c1, 32'h0000_1001, 3'h1, 2'h3, 32'h0000_1004, 3'h0, 2'h0},
        '{32'h0000_00c1, 32'h3fff_ffff, 3'h1, 2'h3, 32'h7fff_fff0, 3'h0, 2'h2},
        '{32'h0000_00c1, 32'h3fff_ffff, 3'h1, 2'h3, 32'h8000_0000, 3'h0, 2'h0},
        '{32'h0800_1041, 32'h0000_1000, 3'h1, 2'h3, 32'h0000_1000, 3'h0, 2'h3}
    };

    hbtu_trigger_unit uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .csr_req_i(req), .csr_we_i(we), .csr_addr_i(a),
        .csr_wdata_i(wd), .csr_debug_mode_i(dbg), .csr_rdata_o(rd), .csr_ack_o(ack), .csr_illegal_o(ill),
        .acc_i(acc), .trap_o(trap));
    hbtu_pipe_model u_pipe (.clk_i(clk_i), .req_i(pr), .acc_o(acc));

    // ********
    // tasks
    // ********
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            errors++;
        end
    endtask : chk

    // request held until the next call so back-to-back accesses never glitch req
    task csr(input logic w, input logic [2:0] i, input logic [31:0] d, input logic m);
        req = 1'b1;
        we = w;
        a = hbtu_pkg::CSR_SELECT + {9'h000, i};
        wd = d;
        dbg = m;
        @(posedge clk_i);
        #1;
        rq = rd;
        aq = ack;
        iq = ill;
    endtask : csr

    // one access through the model; trap sampled one cycle after the unit takes it
    task go(input logic [2:0] k, input logic [1:0] p, input logic [31:0] ad, input logic [2:0] s);
        req = 1'b0;
        dbg = 1'b0;
        pr = '{1'b1, k[0], k[1], k[2], p, ad, s};
        @(posedge clk_i);
        #1 pr.valid = 1'b0;
        @(posedge clk_i);
        #1 tv = {30'h0000_0000, trap.valid, trap.to_debug};
        tc = trap.cause;
        tb = trap.badaddr;
    endtask : go

    task close_out;
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    // ********
    // clock, watchdog, sequence
    // ********
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // whole run is about 104 cycles
    initial
    begin
        #50000;
        errors++;
        close_out();
    end

    initial
    begin
        errors = 0;
        total_checks = 0;
        req = 1'b0;
        we = 1'b0;
        dbg = 1'b0;
        a = 12'h000;
        wd = 32'h0000_0000;
        pr = '0;
        rst_n_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        csr(0, 3'h1, 32'h0000_0000, 1'b0);
        chk("ctrl reset", 32'h2080_0000, rq);
        csr(0, 3'h2, 32'h0000_0000, 1'b0);
        chk("addr reset", 32'h0000_0000, rq);
        // machine mode cannot set dmode; bad action and match codes fold to 0
        csr(1, 3'h1, 32'hffff_ffff, 1'b0);
        csr(0, 3'h1, 32'h0000_0000, 1'b0);
        chk("ctrl legal", 32'h2080_085f, rq);
        foreach (rows[i])
        begin
            csr(1, 3'h1, rows[i].c, 1'b1);
            csr(1, 3'h2, rows[i].m, 1'b1);
            csr(0, 3'h1, 32'h0000_0000, 1'b1);
            chk("ctrl", (rows[i].c & 32'h0800_ffdf) | 32'h2080_0000, rq);
            csr(0, 3'h2, 32'h0000_0000, 1'b1);
            chk("addr", rows[i].m, rq);
            go(rows[i].k, rows[i].p, rows[i].ad, rows[i].s);
            chk("trap", {30'h0000_0000, rows[i].ev}, tv);
        end
        chk("dbg cause", 32'h0000_0000, tc);
        chk("dbg badaddr", 32'h0000_0000, tb);
        // trigger 0 now debug-owned: hidden and refused in machine mode
        csr(0, 3'h1, 32'h0000_0000, 1'b0);
        chk("hidden rd", 32'h0000_0000, rq);
        chk("hidden ill", 32'h0000_0001, {31'h0000_0000, iq});
        csr(1, 3'h2, 32'h5555_0000, 1'b0);
        csr(0, 3'h2, 32'h0000_0000, 1'b1);
        chk("addr kept", 32'h0000_1000, rq);
        // chained range 0x2000 to 0x200f
        csr(1, 3'h1, 32'h0000_0941, 1'b1);
        csr(1, 3'h2, 32'h0000_2000, 1'b1);
        csr(1, 3'h0, 32'h0000_0003, 1'b1);
        csr(0, 3'h0, 32'h0000_0000, 1'b1);
        chk("select", 32'h0000_0001, rq);
        csr(1, 3'h1, 32'h0000_01c1, 1'b1);
        csr(1, 3'h2, 32'h0000_2010, 1'b1);
        go(3'h1, 2'h3, 32'h0000_2008, 3'h0);
        chk("in range", 32'h0000_0002, tv);
        chk("cause", hbtu_pkg::CAUSE_BREAKPOINT, tc);
        chk("badaddr", 32'h0000_2008, tb);
        go(3'h1, 2'h3, 32'h0000_2010, 3'h0);
        chk("above range", 32'h0000_0000, tv);
        go(3'h1, 2'h3, 32'h0000_1fff, 3'h0);
        chk("below range", 32'h0000_0000, tv);
        csr(0, 3'h5, 32'h0000_0000, 1'b0);
        chk("unknown csr", 32'h0000_0000, {31'h0000_0000, aq});
        csr(0, 3'h3, 32'h0000_0000, 1'b1);
        chk("data3", 32'h0000_0000, rq);
        chk("data3 ack", 32'h0000_0001, {31'h0000_0000, aq});
        // second reset in mid-run
        req = 1'b0;
        rst_n_i = 1'b0;
        @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        csr(0, 3'h1, 32'h0000_0000, 1'b0);
        chk("ctrl reset2", 32'h2080_0000, rq);
        close_out();
    end
endmodule : test_hart_breakpoint_trigger_unit
